// ### scf_params.svh
// Purpose: constants for the single clock fifo
// Assumes: included by bare name
// Notes: definitions only
`ifndef SCF_PARAMS_SVH
`define SCF_PARAMS_SVH
`define SCF_DEPTH_DEF 64
`define SCF_INT_BITS_DEF 16
`define SCF_FRAC_BITS_DEF 0
`define SCF_FMT_SIGNED_INT 2'h0
`define SCF_FMT_SIGNED_FRAC 2'h1
`define SCF_FMT_UNSIGNED_INT 2'h2
`define SCF_FMT_INFERRED 2'h3
`define SCF_SKID_DEPTH 2
`endif

// ### scf_pkg.sv
// Purpose: types for the single clock fifo
// Assumes: nothing
// Notes: types only
`default_nettype none
package scf_pkg;
	timeunit 1ns;
	timeprecision 100ps;
	typedef enum logic [1:0] {
		SCF_SIGNED_INT = 2'h0,
		SCF_SIGNED_FRAC = 2'h1,
		SCF_UNSIGNED_INT = 2'h2,
		SCF_INFERRED = 2'h3
	} scf_fmt_e;
	typedef enum logic [1:0] {
		SCF_SKID_EMPTY = 2'h1,
		SCF_SKID_HOLD = 2'h2
	} scf_skid_e;
	typedef struct packed {
		logic full;
		logic empty;
	} scf_flags_s;
endpackage
`default_nettype wire

// ### scf_fifo.sv
// Purpose: parameterised single clock fifo with count, clear and show-ahead read
// Assumes: one clock, inputs synchronous to clk
// Notes: a two-entry skid buffer sits between storage and the write port
`include "scf_params.svh"
`default_nettype none
module scf_fifo #(
	parameter int DEPTH = `SCF_DEPTH_DEF,
	parameter int INT_BITS = `SCF_INT_BITS_DEF,
	parameter int FRAC_BITS_CFG = `SCF_FRAC_BITS_DEF,
	parameter scf_pkg::scf_fmt_e FMT = scf_pkg::SCF_SIGNED_FRAC,
	parameter bit USE_CLEAR = 1'b1,
	parameter bit SHOW_AHEAD = 1'b0,
	parameter int FRAC_BITS = (FMT == scf_pkg::SCF_SIGNED_FRAC) ? FRAC_BITS_CFG : 0,
	parameter int W = INT_BITS + FRAC_BITS,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [W-1:0] wr_data,
	input wire logic wr_req,
	output logic wr_ready,
	input wire logic rd_req,
	input wire logic clear,
	output logic [W-1:0] rd_data,
	output logic data_sign,
	output logic full,
	output logic empty,
	output logic [CW-1:0] used_words
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

	// ==========================================================
	// skid buffer on the write side
	logic [W-1:0] skid_mem_r [`SCF_SKID_DEPTH];
	logic [1:0] skid_cnt_r;
	logic skid_rp_r;
	logic skid_wp_r;
	logic skid_out_valid;
	logic skid_out_ready;
	logic skid_push;
	logic skid_pop;
	logic clr_en;
	scf_pkg::scf_skid_e skid_state;
	assign clr_en = USE_CLEAR && clear;
	assign skid_state = (skid_cnt_r == 2'h0) ? scf_pkg::SCF_SKID_EMPTY : scf_pkg::SCF_SKID_HOLD;
	assign wr_ready = (skid_cnt_r != 2'(`SCF_SKID_DEPTH));
	assign skid_push = wr_req && wr_ready && !clr_en;
	assign skid_out_valid = (skid_state == scf_pkg::SCF_SKID_HOLD);
	assign skid_pop = skid_out_valid && skid_out_ready && !clr_en;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			skid_cnt_r <= 2'h0;
			skid_rp_r <= 1'b0;
			skid_wp_r <= 1'b0;
		end else if (clk_en) begin
			if (clr_en) begin
				skid_cnt_r <= 2'h0;
				skid_rp_r <= 1'b0;
				skid_wp_r <= 1'b0;
			end else begin
				skid_cnt_r <= skid_cnt_r + 2'(skid_push) - 2'(skid_pop);
				skid_rp_r <= skid_rp_r ^ skid_pop;
				skid_wp_r <= skid_wp_r ^ skid_push;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (clk_en && skid_push) begin
			skid_mem_r[skid_wp_r] <= wr_data;
		end
	end

	// ==========================================================
	// main storage
	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic [W-1:0] rd_data_r;
	logic do_wr;
	logic do_rd;
	scf_pkg::scf_flags_s flags;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	assign flags.full = (cnt_r == DEPTH_C);
	assign flags.empty = (cnt_r == '0);
	assign full = flags.full;
	assign empty = flags.empty;
	assign skid_out_ready = !flags.full;
	assign do_wr = skid_pop;
	assign do_rd = rd_req && !flags.empty && !clr_en;
	assign cnt_nxt = cnt_r + CW'(do_wr) - CW'(do_rd);
	assign used_words = cnt_r;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= '0;
			wp_r <= '0;
			rp_r <= '0;
		end else if (clk_en) begin
			if (clr_en) begin
				cnt_r <= '0;
				wp_r <= '0;
				rp_r <= '0;
			end else begin
				cnt_r <= cnt_nxt;
				if (do_wr) wp_r <= ptr_inc(wp_r);
				if (do_rd) rp_r <= ptr_inc(rp_r);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (clk_en && do_wr) begin
			mem_r[wp_r] <= skid_mem_r[skid_rp_r];
		end
	end

	// normal mode output register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_r <= '0;
		end else if (clk_en && do_rd) begin
			rd_data_r <= mem_r[rp_r];
		end
	end

	// ==========================================================
	// show-ahead head register
	logic [AW-1:0] rp_nxt;
	logic head_zero;
	logic head_bypass;
	logic [W-1:0] head_nxt;
	logic [W-1:0] head_r;
	assign rp_nxt = do_rd ? ptr_inc(rp_r) : rp_r;
	assign head_zero = clr_en || (cnt_nxt == '0);
	assign head_bypass = do_wr && (wp_r == rp_nxt);
	assign head_nxt = head_zero ? '0 : (head_bypass ? skid_mem_r[skid_rp_r] : mem_r[rp_nxt]);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			head_r <= '0;
		end else if (clk_en) begin
			head_r <= head_nxt;
		end
	end

	assign rd_data = SHOW_AHEAD ? head_r : rd_data_r;
	assign data_sign = (FMT == scf_pkg::SCF_UNSIGNED_INT) ? 1'b0 : rd_data[W-1];

	// ==========================================================
	// checks
	full_blocks_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && full && !rd_req && !clr_en |=> used_words == $past(used_words))
		else $error("count moved while full without read");
	empty_blocks_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && empty && !skid_out_valid |=> empty)
		else $error("left empty with no write");
	count_step_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && !clr_en && do_wr && !do_rd |=> used_words == $past(used_words) + 1'b1)
		else $error("count did not rise on write");
	count_down_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && !clr_en && do_rd && !do_wr |=> used_words == $past(used_words) - 1'b1)
		else $error("count did not fall on read");
	count_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && do_wr && do_rd |=> $stable(used_words))
		else $error("count changed on read and write");
	clear_empties_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && clr_en |=> empty && used_words == '0 && wr_ready)
		else $error("clear did not empty");
	count_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
		used_words <= DEPTH_C)
		else $error("count over depth");
	flag_tie_a: assert property (@(posedge clk) disable iff (!rst_b)
		!(full && empty))
		else $error("full and empty together");
	read_data_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && do_rd && !SHOW_AHEAD |=> rd_data == $past(mem_r[rp_r]))
		else $error("read word wrong");
	freeze_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		!clk_en |=> $stable(used_words) && $stable(rd_data) && $stable(wr_ready))
		else $error("state moved while clock enable low");
	store_word_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && do_wr |=> mem_r[$past(wp_r)] == $past(skid_mem_r[skid_rp_r]))
		else $error("stored word wrong");
	head_next_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && do_rd && SHOW_AHEAD && cnt_r > CW'(1) |=>
		rd_data == $past(mem_r[ptr_inc(rp_r)]))
		else $error("show-ahead did not advance");
	head_match_a: assert property (@(posedge clk) disable iff (!rst_b)
		SHOW_AHEAD && !empty |-> rd_data == mem_r[rp_r])
		else $error("show-ahead head wrong");
	clear_off_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && !USE_CLEAR && clear && !empty && !rd_req |=> !empty)
		else $error("clear acted while disabled");
	empty_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && empty && rd_req && !SHOW_AHEAD |=> $stable(rd_data))
		else $error("read on empty changed data");
endmodule
`default_nettype wire

// ### scf_reader.sv
// Purpose: read-side user logic model for the fifo
// Assumes: bench drives go at the falling edge
// Notes: holds the read request level while go is high
`default_nettype none
module scf_reader (
	input wire logic go,
	output logic rd_req
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========
	// read request
	assign rd_req = go;
endmodule
`default_nettype wire

// ### scf_fifo_bench.sv
// Purpose: self-checking bench for scf_fifo
// Assumes: depth 4; one normal instance with clear, one show-ahead instance without
// Notes: inputs change at the falling edge
`default_nettype none
module scf_fifo_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int D = 4;
	logic clk = 0, rst_b = 0, clk_en = 1, wr_req = 0, go = 0, clear = 0;
	logic [15:0] wr_data = 16'h0;
	logic rd_req, wr_ready, data_sign, full, empty;
	logic [15:0] rd_data;
	logic [2:0] used_words;
	logic sa_wr_ready, sa_data_sign, sa_full, sa_empty;
	logic [15:0] sa_rd_data;
	logic [2:0] sa_used_words;
	int fails = 0;
	int cmp_count = 0;
	always #12.5 clk = ~clk;
	// ==========
	// instances
	scf_fifo #(.DEPTH(D)) dut_u (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
		.wr_data(wr_data), .wr_req(wr_req), .wr_ready(wr_ready), .rd_req(rd_req),
		.clear(clear), .rd_data(rd_data), .data_sign(data_sign), .full(full),
		.empty(empty), .used_words(used_words));
	scf_reader rd_u (.go(go), .rd_req(rd_req));
	scf_fifo #(.DEPTH(D), .FRAC_BITS_CFG(4), .FMT(scf_pkg::SCF_UNSIGNED_INT), .USE_CLEAR(1'b0),
		.SHOW_AHEAD(1'b1)) dut_sa_u (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
		.wr_data(wr_data), .wr_req(wr_req), .wr_ready(sa_wr_ready), .rd_req(rd_req),
		.clear(clear), .rd_data(sa_rd_data), .data_sign(sa_data_sign), .full(sa_full),
		.empty(sa_empty), .used_words(sa_used_words));
	// ==========
	// tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			while (wr_ready !== 1'b1) @(negedge clk);
			wr_data = b + 16'(i);
			wr_req = 1;
			@(negedge clk);
		end
		wr_req = 0;
	endtask
	task automatic rd(input logic [15:0] b, input int n);
		go = 1;
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			chk(rd_data, b + 16'(i));
			chk(16'(data_sign), 16'(b[15]));
		end
		go = 0;
	endtask
	task automatic final_report();
		$display("checks %0d fails %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==========
	// tests
	initial begin
		repeat (2) @(negedge clk);
		rst_b = 1;
		chk(16'(empty), 16'h1);
		chk(16'(used_words), 16'h0);
		chk(sa_rd_data, 16'h0);
		wr(16'h8a00, D + 2);
		repeat (2) @(negedge clk);
		chk(16'(full), 16'h1);
		chk(16'(used_words), 16'(D));
		chk(16'(wr_ready), 16'h0);
		chk(16'(sa_full), 16'h1);
		chk(sa_rd_data, 16'h8a00);
		chk(16'(sa_data_sign), 16'h0);
		chk(16'(dut_sa_u.W), 16'h10);
		rd(16'h8a00, D + 2);
		chk(16'(empty), 16'h1);
		chk(16'(used_words), 16'h0);
		@(negedge clk);
		rd(16'h8a00 + 16'(D + 1), 1);
		chk(16'(used_words), 16'h0);
		wr(16'h0120, 2);
		repeat (3) @(negedge clk);
		chk(16'(used_words), 16'h2);
		clear = 1;
		@(negedge clk);
		clear = 0;
		chk(16'(empty), 16'h1);
		chk(16'(used_words), 16'h0);
		chk(16'(sa_used_words), 16'h2);
		chk(16'(sa_wr_ready), 16'h1);
		chk(sa_rd_data, 16'h0120);
		wr(16'h0123, 1);
		repeat (2) @(negedge clk);
		chk(16'(used_words), 16'h1);
		rd(16'h0123, 1);
		chk(16'(empty), 16'h1);
		chk(sa_rd_data, 16'h0121);
		chk(16'(sa_empty), 16'h0);
		clk_en = 0;
		wr(16'h0456, 1);
		repeat (2) @(negedge clk);
		chk(16'(used_words), 16'h0);
		chk(16'(sa_used_words), 16'h2);
		clk_en = 1;
		final_report();
	end
	initial begin
		#50000;
		fails++;
		final_report();
	end
endmodule
`default_nettype wire
